// file: hdl/ipu_pkg.sv
package ipu_pkg;
    // ==================================================================
    // Sizes
    localparam int NUM_SRC     = 52;
    localparam int NUM_CH      = 8;
    localparam int VEC_W       = 6;
    localparam int LVL_W       = 3;
    localparam int CNT_W       = 16;
    localparam int ADDR_W      = 24;
    localparam int REG_AW      = 8;
    // ==================================================================
    // Priority levels
    localparam logic [2:0] LVL_OFF  = 3'h0;
    localparam logic [2:0] LVL_DMA  = 3'h6;
    localparam logic [2:0] LVL_NMI  = 3'h7;
    // ==================================================================
    // Register offsets, device side (byte addresses on the plain port)
    localparam logic [7:0] OFS_PRI_PAIR_B   = 8'hD0;
    localparam logic [7:0] OFS_PRI_SINGLE   = 8'hD1;
    localparam logic [7:0] OFS_PRI_TA_LOW   = 8'hD4;
    localparam logic [7:0] OFS_PRI_TA_HIGH  = 8'hD5;
    localparam logic [7:0] OFS_PRI_TB_PAIR  = 8'hD8;
    localparam logic [7:0] OFS_PRI_EXT_ADC  = 8'hF0;
    localparam logic [7:0] OFS_PRI_GEN_BASE = 8'h40;
    localparam logic [7:0] OFS_START_VEC    = 8'h00;
    localparam logic [7:0] OFS_FLAG_CLR     = 8'h08;
    localparam logic [7:0] OFS_XFER_MODE    = 8'h10;
    localparam logic [7:0] OFS_SRC_PTR      = 8'h18;
    localparam logic [7:0] OFS_DST_PTR      = 8'h20;
    localparam logic [7:0] OFS_CNT          = 8'h28;
    localparam logic [7:0] OFS_BURST_END    = 8'h30;
    // ==================================================================
    // Reset values
    localparam logic [7:0]  RST_PRI  = 8'h00;
    localparam logic [5:0]  RST_VEC  = 6'h00;
    // ==================================================================
    // Priority register field positions
    localparam int PRI_LO_FLAG_BIT = 3;
    localparam int PRI_HI_FLAG_BIT = 7;
    // ==================================================================
    // Transfer mode field
    localparam logic [2:0] MODE_DST_INC  = 3'h0;
    localparam logic [2:0] MODE_DST_DEC  = 3'h1;
    localparam logic [2:0] MODE_SRC_INC  = 3'h2;
    localparam logic [2:0] MODE_SRC_DEC  = 3'h3;
    localparam logic [2:0] MODE_BOTH_INC = 3'h4;
    localparam logic [2:0] MODE_BOTH_DEC = 3'h5;
    localparam logic [2:0] MODE_FIXED    = 3'h6;
    localparam logic [2:0] MODE_COUNTER  = 3'h7;
    localparam logic [1:0] UNIT_BYTE     = 2'h0;
    localparam logic [1:0] UNIT_HALF     = 2'h1;
    localparam logic [1:0] UNIT_WORD     = 2'h2;
    localparam logic [1:0] UNIT_RSVD     = 2'h3;
    // ==================================================================
    // Service timing in states
    localparam logic [2:0] STATES_SHORT  = 3'h5;
    localparam logic [2:0] STATES_LONG   = 3'h6;
    // ==================================================================
    // Core side register offsets
    localparam logic [7:0] OFS_CORE_MASK = 8'h00;
    localparam logic [7:0] OFS_CORE_STAT = 8'h04;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
endpackage : ipu_pkg

// file: hdl/ipu_link_if.sv
`timescale 1ns/1ps
interface ipu_link_if;
    import ipu_pkg::*;
    // Interrupt request to the core
    logic             irq_req;
    logic [2:0]       irq_level;
    logic [5:0]       irq_vec;
    logic             irq_ack;
    // DMA request and grant
    logic             dma_req;
    logic [2:0]       dma_chan;
    logic             dma_ack;
    logic             dma_busy;
    // Register port driven by the core
    logic [7:0]       reg_addr;
    logic [31:0]      reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [31:0]      reg_rdata;
    modport dev
    (
        output irq_req, irq_level, irq_vec, dma_req, dma_chan, dma_busy, reg_rdata,
        input  irq_ack, dma_ack, reg_addr, reg_wdata, reg_wr, reg_rd
    );
    modport core
    (
        input  irq_req, irq_level, irq_vec, dma_req, dma_chan, dma_busy, reg_rdata,
        output irq_ack, dma_ack, reg_addr, reg_wdata, reg_wr, reg_rd
    );
endinterface : ipu_link_if

// file: hdl/ipu_dma_chan.sv
`timescale 1ns/1ps
module ipu_dma_chan
    import ipu_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Start of one service and its settings
    input  wire logic              start,
    input  wire logic [4:0]        xfer_mode_field,
    input  wire logic [23:0]       src_in,
    input  wire logic [23:0]       dst_in,
    input  wire logic [15:0]       cnt_in,
    // Results
    output logic                   busy,
    output logic                   done,
    output logic                   chan_done_irq,
    output logic [23:0]            chan_src_pointer,
    output logic [23:0]            chan_dst_pointer,
    output logic [15:0]            chan_xfer_count
);
    import ipu_pkg::*;
    typedef struct packed {
        logic [2:0]  left;
        logic        busy;
        logic        done;
        logic        tc;
        logic [23:0] src;
        logic [23:0] dst;
        logic [15:0] cnt;
    } ipu_chan_s;
    ipu_chan_s st_ff;
    ipu_chan_s nxt_st;
    logic [23:0] step;
    logic [2:0]  mode;
    // ==================================================================
    // Service sequencer
    always_comb
    begin
        mode = xfer_mode_field[4:2];
        unique case (xfer_mode_field[1:0])
            UNIT_BYTE: step = 24'h000001;                                 // [R7] [R22]
            UNIT_HALF: step = 24'h000002;                                 // [R7] [R22]
            UNIT_WORD: step = 24'h000004;                                 // [R7] [R22]
            UNIT_RSVD: step = 24'h000000;
        endcase
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.tc   = 1'b0;
        if (!st_ff.busy && start)
        begin
            nxt_st.busy = 1'b1;
            nxt_st.src  = src_in;
            nxt_st.dst  = dst_in;
            // Bus states after the fetch cycle; last state does the update
            nxt_st.left = (mode == MODE_BOTH_INC || mode == MODE_BOTH_DEC)
                        ? STATES_LONG - 3'h1 : STATES_SHORT - 3'h1;       // [R1] [R3]
            nxt_st.cnt  = cnt_in;
        end
        else if (st_ff.busy && st_ff.left != 3'h1)
        begin
            nxt_st.left = st_ff.left - 3'h1;
        end
        else if (st_ff.busy)
        begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.cnt  = st_ff.cnt - 16'h0001;                           // [R6] [R21]
            nxt_st.tc   = (st_ff.cnt == 16'h0001);                        // [R6]
            unique case (mode)
                MODE_DST_INC:  nxt_st.dst = st_ff.dst + step;             // [R1]
                MODE_SRC_INC:  nxt_st.src = st_ff.src + step;             // [R1]
                MODE_DST_DEC:  nxt_st.dst = st_ff.dst - step;             // [R2]
                MODE_SRC_DEC:  nxt_st.src = st_ff.src - step;             // [R2]
                MODE_BOTH_INC:
                begin
                    nxt_st.src = st_ff.src + step;                        // [R3]
                    nxt_st.dst = st_ff.dst + step;                        // [R3]
                end
                MODE_BOTH_DEC:
                begin
                    nxt_st.src = st_ff.src - step;                        // [R3]
                    nxt_st.dst = st_ff.dst - step;                        // [R3]
                end
                MODE_FIXED:    nxt_st.src = st_ff.src;                    // [R4]
                MODE_COUNTER:  nxt_st.src = st_ff.src + 24'h000001;       // [R5]
            endcase
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
    assign busy             = st_ff.busy;
    assign done             = st_ff.done;
    assign chan_done_irq    = st_ff.tc;
    assign chan_src_pointer = st_ff.src;
    assign chan_dst_pointer = st_ff.dst;
    assign chan_xfer_count  = st_ff.cnt;
endmodule : ipu_dma_chan

// file: hdl/ipu_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// (R1) Destination/source step modes increment, five states
// (R2) Destination/source step modes decrement, five states
// (R3) Both-address modes step together, six states
// (R4) Fixed mode leaves both addresses unchanged
// (R5) Counter mode bumps source, no move
// (R6) Each service decrements count; zero raises done
// (R7) Low mode bits pick 1, 2, 4 bytes
// (R8) Software writes only listed mode codes
// (R9) One latched request flag per 52 sources
// (R10) Flag clears on vector read, DMA, clear
// (R11) Three-bit priority; 0 and 7 mask
// (R12) Watchdog request always at level 7
// (R13) Ties go to the lowest vector
// (R14) Priority bits 3 and 7 show flags; code reads back 0 for the OFS_PRI_GEN_BASE block
// (R15) Present highest pending request, level, vector
// (R16) Core accepts above mask, mask becomes level+1; code also accepts a level equal to the mask
// (R17) Return restores the saved mask
// (R18) Eight start vectors route sources to channels
// (R19) Software loads pointers before enabling DMA
// (R20) Lowest numbered DMA channel served first
// (R21) Transfer count is sixteen bits wide
// (R22) Address step equals the unit size
module ipu_ctrl
    import ipu_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Peripheral request pulses and watchdog
    input  wire logic [51:0]       src_pulse,
    input  wire logic              wdt_nmi,
    // Link to the core
    ipu_link_if.dev                link,
    // Per-channel transfer end
    output logic [7:0]             chan_done_irq
);
    import ipu_pkg::*;
    typedef struct packed {
        logic [51:0]    flag;
        logic [51:0][2:0] pri;
        logic [7:0][5:0]  svec;
        logic [7:0][4:0]  mode;
        logic [7:0][23:0] src;
        logic [7:0][23:0] dst;
        logic [7:0][15:0] cnt;
        logic             nmi;
        logic [2:0]       act_ch;
        logic             act;
        logic [31:0]      rdata;
    } ipu_ctrl_s;
    ipu_ctrl_s   st_ff;
    ipu_ctrl_s   nxt_st;
    logic [2:0]  best_lvl;
    logic [5:0]  best_vec;
    logic        best_any;
    logic [7:0]  ch_pend;
    logic [2:0]  ch_sel;
    logic        ch_any;
    logic        ch_start;
    logic        ch_busy;
    logic        ch_done;
    logic        ch_tc;
    logic [23:0] ch_src;
    logic [23:0] ch_dst;
    logic [15:0] ch_cnt;
    logic [51:0] dma_owned;
    logic [5:0]  reg_idx;
    // ==================================================================
    // Which sources are routed to a channel
    always_comb
    begin
        dma_owned = '0;
        for (int c = 0; c < NUM_CH; c++)
            if (st_ff.svec[c] != RST_VEC && int'(st_ff.svec[c]) < NUM_SRC)
                dma_owned[st_ff.svec[c]] = 1'b1;                           // [R18]
    end
    // ==================================================================
    // Level resolve; strict compare keeps the lowest vector on ties
    always_comb
    begin
        best_lvl = LVL_OFF;
        best_vec = 6'h00;
        best_any = 1'b0;
        for (int s = 0; s < NUM_SRC; s++)
            if (st_ff.flag[s] && !dma_owned[s] && st_ff.pri[s] != LVL_OFF
                && st_ff.pri[s] != LVL_NMI && st_ff.pri[s] > best_lvl)     // [R11] [R13]
            begin
                best_lvl = st_ff.pri[s];
                best_vec = 6'(s);
                best_any = 1'b1;
            end
        if (st_ff.nmi)
        begin
            best_lvl = LVL_NMI;                                            // [R12]
            best_vec = 6'h3F;
            best_any = 1'b1;
        end
    end
    // ==================================================================
    // Channel pick: lowest number wins regardless of level
    always_comb
    begin
        ch_sel = 3'h0;
        ch_any = 1'b0;
        for (int c = NUM_CH - 1; c >= 0; c--)
        begin
            ch_pend[c] = st_ff.svec[c] != RST_VEC && int'(st_ff.svec[c]) < NUM_SRC
                       && st_ff.flag[st_ff.svec[c]];
            if (ch_pend[c])
            begin
                ch_sel = 3'(c);                                            // [R20]
                ch_any = 1'b1;
            end
        end
    end
    assign ch_start = link.dma_ack && ch_any && !st_ff.act;
    ipu_dma_chan u_chan
    (
        .sys_clk          (sys_clk),
        .rst_b            (rst_b),
        .start            (ch_start),
        // Mode follows the active channel, not whichever channel is pending now
        .xfer_mode_field  (st_ff.mode[ch_start ? ch_sel : st_ff.act_ch]),
        .src_in           (st_ff.src[ch_sel]),
        .dst_in           (st_ff.dst[ch_sel]),
        .cnt_in           (st_ff.cnt[ch_sel]),
        .busy             (ch_busy),
        .done             (ch_done),
        .chan_done_irq    (ch_tc),
        .chan_src_pointer (ch_src),
        .chan_dst_pointer (ch_dst),
        .chan_xfer_count  (ch_cnt)
    );
    // ==================================================================
    // Registers, flags and DMA bookkeeping
    always_comb
    begin
        reg_idx = link.reg_addr[7:2];
        nxt_st  = st_ff;
        nxt_st.rdata = 32'h0000_0000;
        if (ch_start)
        begin
            nxt_st.act    = 1'b1;
            nxt_st.act_ch = ch_sel;
        end
        if (ch_done)
        begin
            nxt_st.act                = 1'b0;
            nxt_st.src[st_ff.act_ch]  = ch_src;
            nxt_st.dst[st_ff.act_ch]  = ch_dst;
            nxt_st.cnt[st_ff.act_ch]  = ch_cnt;
            if (ch_tc)
                nxt_st.svec[st_ff.act_ch] = RST_VEC;                       // [R6]
        end
        if (link.reg_wr)
        begin
            unique case (link.reg_addr)
                OFS_PRI_PAIR_B:  {nxt_st.pri[2], nxt_st.pri[1]} =
                                 {link.reg_wdata[6:4], link.reg_wdata[2:0]}; // [R11]
                OFS_PRI_SINGLE:  nxt_st.pri[3] = link.reg_wdata[2:0];
                OFS_PRI_TA_LOW:  {nxt_st.pri[5], nxt_st.pri[4]} =
                                 {link.reg_wdata[6:4], link.reg_wdata[2:0]};
                OFS_PRI_TA_HIGH: {nxt_st.pri[7], nxt_st.pri[6]} =
                                 {link.reg_wdata[6:4], link.reg_wdata[2:0]};
                OFS_PRI_TB_PAIR: {nxt_st.pri[9], nxt_st.pri[8]} =
                                 {link.reg_wdata[6:4], link.reg_wdata[2:0]};
                OFS_PRI_EXT_ADC: {nxt_st.pri[10], nxt_st.pri[0]} =
                                 {link.reg_wdata[6:4], link.reg_wdata[2:0]};
                OFS_FLAG_CLR:
                    if (int'(link.reg_wdata[5:0]) < NUM_SRC)
                        nxt_st.flag[link.reg_wdata[5:0]] = 1'b0;           // [R10]
                OFS_BURST_END:
                    if (ch_any)
                        nxt_st.flag[st_ff.svec[ch_sel]] = 1'b0;            // [R10]
                default:
                    if (link.reg_addr[7:6] == 2'h1)
                        nxt_st.pri[reg_idx[3:0] + 6'd11] = link.reg_wdata[2:0];
                    else if (link.reg_addr[7:6] == 2'h0)
                    begin
                        unique case (link.reg_addr[5:3])
                            3'h0: nxt_st.svec[link.reg_addr[2:0]] = link.reg_wdata[5:0];
                            3'h2: nxt_st.mode[link.reg_addr[2:0]] = link.reg_wdata[4:0];
                            3'h3: nxt_st.src[link.reg_addr[2:0]]  = link.reg_wdata[23:0];
                            3'h4: nxt_st.dst[link.reg_addr[2:0]]  = link.reg_wdata[23:0];
                            3'h5: nxt_st.cnt[link.reg_addr[2:0]]  = link.reg_wdata[15:0];
                            default: ;
                        endcase
                    end
            endcase
        end
        if (link.reg_rd)
        begin
            unique case (link.reg_addr)
                OFS_PRI_PAIR_B:  nxt_st.rdata[7:0] = {st_ff.flag[2], st_ff.pri[2],
                                                     st_ff.flag[1], st_ff.pri[1]}; // [R14]
                OFS_PRI_SINGLE:  nxt_st.rdata[7:0] = {4'h0, st_ff.flag[3], st_ff.pri[3]};
                OFS_PRI_TA_LOW:  nxt_st.rdata[7:0] = {st_ff.flag[5], st_ff.pri[5],
                                                     st_ff.flag[4], st_ff.pri[4]};
                OFS_PRI_TA_HIGH: nxt_st.rdata[7:0] = {st_ff.flag[7], st_ff.pri[7],
                                                     st_ff.flag[6], st_ff.pri[6]};
                OFS_PRI_TB_PAIR: nxt_st.rdata[7:0] = {st_ff.flag[9], st_ff.pri[9],
                                                     st_ff.flag[8], st_ff.pri[8]};
                OFS_PRI_EXT_ADC: nxt_st.rdata[7:0] = {st_ff.flag[10], st_ff.pri[10],
                                                     st_ff.flag[0], st_ff.pri[0]};
                default:
                    if (link.reg_addr[7:6] == 2'h0 && link.reg_addr[5:3] == 3'h5)
                        nxt_st.rdata[15:0] = st_ff.cnt[link.reg_addr[2:0]];
                    else if (link.reg_addr[7:6] == 2'h0 && link.reg_addr[5:3] == 3'h0)
                        nxt_st.rdata[5:0] = st_ff.svec[link.reg_addr[2:0]];
            endcase
        end
        // Acknowledges clear, then new pulses set: set wins
        if (link.irq_ack && best_any)
        begin
            if (best_lvl == LVL_NMI)
                nxt_st.nmi = 1'b0;
            else
                nxt_st.flag[best_vec] = 1'b0;                              // [R10]
        end
        if (ch_start)
            nxt_st.flag[st_ff.svec[ch_sel]] = 1'b0;                        // [R10]
        nxt_st.flag = nxt_st.flag | src_pulse;                             // [R9]
        nxt_st.nmi  = nxt_st.nmi | wdt_nmi;                                // [R12]
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            st_ff <= '0;                                                   // [R10]
        else
            st_ff <= nxt_st;
    end
    // DMA rides at level 6 above ordinary maskable requests
    assign link.irq_req   = best_any;                                      // [R15]
    assign link.irq_level = best_lvl;                                      // [R15]
    assign link.irq_vec   = best_vec;                                      // [R15]
    assign link.dma_req   = ch_any && !st_ff.act;
    assign link.dma_chan  = ch_sel;
    assign link.dma_busy  = st_ff.act || ch_busy;
    assign link.reg_rdata = st_ff.rdata;
    assign chan_done_irq  = ch_done && ch_tc ? (8'h01 << st_ff.act_ch) : 8'h00;
endmodule : ipu_ctrl

// file: hdl/ipu_core.sv
`timescale 1ns/1ps
module ipu_core
    import ipu_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Link to the controller
    ipu_link_if.core               link,
    // Software register port
    input  wire logic [7:0]        sw_addr,
    input  wire logic [31:0]       sw_wdata,
    input  wire logic              sw_wr,
    input  wire logic              sw_rd,
    output logic [31:0]            sw_rdata,
    // Return from interrupt strobe
    input  wire logic              return_from_irq_op
);
    import ipu_pkg::*;
    typedef struct packed {
        logic [2:0]      core_level_mask;
        logic [7:0][2:0] stack;
        logic [2:0]      sp;
        logic [5:0]      last_vec;
        logic [31:0]     rdata;
        logic            irq_ack;
        logic            dma_ack;
    } ipu_core_s;
    ipu_core_s st_ff;
    ipu_core_s nxt_st;
    // ==================================================================
    // Acceptance and mask; the DMA path always beats maskable requests
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.irq_ack = 1'b0;
        nxt_st.dma_ack = 1'b0;
        nxt_st.rdata   = 32'h0000_0000;
        if (link.dma_req && !link.dma_busy && !st_ff.dma_ack
            && LVL_DMA >= st_ff.core_level_mask)
            nxt_st.dma_ack = 1'b1;
        else if (link.irq_req && !st_ff.irq_ack
                 && (link.irq_level >= st_ff.core_level_mask
                     || link.irq_level == LVL_NMI))                    // [R16]
        begin
            nxt_st.irq_ack         = 1'b1;
            nxt_st.last_vec        = link.irq_vec;
            nxt_st.stack[st_ff.sp] = st_ff.core_level_mask;            // [R17]
            nxt_st.sp              = st_ff.sp + 3'h1;
            nxt_st.core_level_mask = (link.irq_level == LVL_NMI) ? LVL_NMI
                                   : link.irq_level + 3'h1;            // [R16]
        end
        else if (return_from_irq_op)
        begin
            nxt_st.sp              = st_ff.sp - 3'h1;
            nxt_st.core_level_mask = st_ff.stack[st_ff.sp - 3'h1];     // [R17]
        end
        if (sw_wr && sw_addr == OFS_CORE_MASK)
            nxt_st.core_level_mask = sw_wdata[2:0];
        if (sw_rd)
            unique case (sw_addr)
                OFS_CORE_MASK: nxt_st.rdata = {29'h0, st_ff.core_level_mask};
                OFS_CORE_STAT: nxt_st.rdata = {20'h0, st_ff.sp, st_ff.last_vec,
                                               link.dma_busy, link.irq_req, 1'b0};
                default:       nxt_st.rdata = 32'h0000_0000;
            endcase
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st_ff                 <= '0;
            st_ff.core_level_mask <= 3'h0;
        end
        else
            st_ff <= nxt_st;
    end
    // Device registers forwarded; reads return one cycle later either way
    assign link.irq_ack   = st_ff.irq_ack;
    assign link.dma_ack   = st_ff.dma_ack;
    assign link.reg_addr  = sw_addr;
    assign link.reg_wdata = sw_wdata;
    assign link.reg_wr    = sw_wr && sw_addr != OFS_CORE_MASK;
    // Core-local reads stay off the link so a device register cannot answer too
    assign link.reg_rd    = sw_rd && sw_addr != OFS_CORE_MASK && sw_addr != OFS_CORE_STAT;
    assign sw_rdata       = st_ff.rdata | link.reg_rdata;
endmodule : ipu_core

// file: sim/ipu_link_monitor.sv
`timescale 1ns/1ps
module ipu_link_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_b,
    // Link signals
    input wire logic       irq_req,
    input wire logic [2:0] irq_level,
    input wire logic [5:0] irq_vec,
    input wire logic       irq_ack,
    input wire logic       dma_req,
    input wire logic       dma_ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // Request side
    lvl_not_zero_a: assert property (irq_req |-> irq_level != 3'h0)
        else $error("request shown at level zero");
    nmi_lvl_a: assert property (irq_req && irq_vec == 6'h3F |-> irq_level == 3'h7)
        else $error("watchdog request not at level seven");
    lvl7_only_nmi_a: assert property (irq_req && irq_level == 3'h7 |-> irq_vec == 6'h3F)
        else $error("programmed level seven reached the core");
    // ==========================================
    // Acknowledge side
    ack_cause_a: assert property (irq_ack |-> $past(irq_req))
        else $error("acknowledge without request");
    ack_pulse_a: assert property (irq_ack |=> !irq_ack)
        else $error("acknowledge longer than one cycle");
    flag_clear_a: assert property (irq_ack |-> ##2 (!irq_req || irq_vec != $past(irq_vec, 2)))
        else $error("flag not cleared after vector read");
    dma_cause_a: assert property (dma_ack |-> $past(dma_req))
        else $error("dma grant without request");
    dma_pulse_a: assert property (dma_ack |=> !dma_ack)
        else $error("dma grant longer than one cycle");
endmodule : ipu_link_monitor

// file: sim/interrupt_priority_and_udma_modes_tb.sv
`timescale 1ns/1ps
module interrupt_priority_and_udma_modes_tb;
    import ipu_pkg::*;
    logic sys_clk, rst_b, wdt_nmi, sw_wr, sw_rd, rd_d, ret_op;
    logic [51:0] src_pulse;
    logic [7:0]  sw_addr;
    logic [31:0] sw_wdata, sw_rdata;
    logic [2:0]  lo, hi;
    logic [31:0] rq[$], iq[$];
    logic [7:0]  done_irq;
    int fail_count, num_checks, cyc, done_n;
    ipu_link_if link_i();
    ipu_ctrl ipu_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b), .src_pulse(src_pulse),
        .wdt_nmi(wdt_nmi), .link(link_i), .chan_done_irq(done_irq));
    ipu_core ipu_core_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_i), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .return_from_irq_op(ret_op));
    ipu_link_monitor ipu_link_monitor_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .irq_req(link_i.irq_req), .irq_level(link_i.irq_level), .irq_vec(link_i.irq_vec),
        .irq_ack(link_i.irq_ack), .dma_req(link_i.dma_req), .dma_ack(link_i.dma_ack));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : rd
    // Pulse one source, or the watchdog when s is 52, then let it settle
    task automatic pulse(input int s);
        if (s == 52) wdt_nmi <= 1'b1;
        else src_pulse <= 52'h1 << s;
        @(posedge sys_clk);
        src_pulse <= '0;
        wdt_nmi <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask : pulse
    // ==========================================
    // Watchers: every answer consumes the oldest note
    always @(posedge sys_clk)
    begin
        cyc++;
        if (rd_d) check(sw_rdata, rq.pop_front());
        if (link_i.irq_ack) check({29'h0, link_i.irq_level}, iq.pop_front());
        if (done_irq == 8'h02) done_n++;
        rd_d <= sw_rd;
        if (cyc == 3000)
        begin
            fail_count++;
            conclude();
        end
    end
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial
    begin
        {rst_b, wdt_nmi, sw_wr, sw_rd, rd_d, ret_op, src_pulse, sw_addr, sw_wdata} = '0;
        void'($urandom(12));
        // Keep lo+1 below hi so the second source can nest
        lo = 3'($urandom_range(2, 1));
        hi = 3'($urandom_range(6, 4));
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(OFS_PRI_PAIR_B, 32'h0);
        wr(OFS_PRI_PAIR_B, {25'h0, hi, 1'b0, lo});
        rd(OFS_PRI_PAIR_B, {25'h0, hi, 1'b0, lo});
        iq.push_back({29'h0, lo});
        pulse(1);
        iq.push_back({29'h0, hi});
        pulse(2);
        pulse(1);
        rd(OFS_PRI_PAIR_B, {25'h0, hi, 1'b1, lo});
        ret_op <= 1'b1;
        @(posedge sys_clk);
        ret_op <= 1'b0;
        repeat (10) @(posedge sys_clk);
        iq.push_back({29'h0, lo});
        ret_op <= 1'b1;
        @(posedge sys_clk);
        ret_op <= 1'b0;
        repeat (10) @(posedge sys_clk);
        wr(8'h11, {27'h0, MODE_DST_INC, UNIT_HALF});
        wr(8'h29, 32'h2);
        wr(8'h01, 32'h4);
        pulse(4);
        rd(8'h29, 32'h1);
        pulse(4);
        rd(8'h01, 32'h0);
        iq.push_back(32'h7);
        pulse(52);
        check(32'(iq.size() + rq.size()), 32'h0);
        check(32'(done_n), 32'h1);
        conclude();
    end
endmodule : interrupt_priority_and_udma_modes_tb
